// File: testbench.sv
// testbench: enable, count, clear, sleep/wake and idle tests
`timescale 1ns/100ps
module testbench;
    import wsw_pkg::*;
    logic                 clk, rst_n, cfg_en, erased, sw_ce, kick, req, mode;
    logic                 irq, por, pin, lp_sl, lock, rcwe, clr, psav, pmode;
    logic [1:0]           fam, cur, src;
    logic [3:0]           fmode;
    logic [7:0]           rcw;
    logic [WDT_WIDTH-1:0] cnt, c0;
    logic                 en, swo, tof, wrst, cpu, per, osc, rc, slp, idl;
    int                   n_fail, n_checks, wait_n;

    wsw_top #(.POWER_UP_TIMER_CYC(8), .OST_CYC(8), .WDT_LIMIT(16'h01ff)) i_wsw_top (
        .i_clk(clk), .i_rst_n(rst_n), .i_cfg_watchdog_enable(cfg_en), .i_cfg_erased(erased),
        .i_cfg_osc_family(fam), .i_cfg_primary_osc_mode(fmode), .i_clk_switch_en(sw_ce),
        .i_current_osc_select(cur), .i_reset_control_reg_wr(rcw), .i_reset_control_reg_we(rcwe),
        .i_clear_watchdog_instr(clr), .i_power_save_instr(psav), .i_power_save_mode(pmode),
        .i_irq_wake(irq), .i_por_bor(por), .i_pin_reset(pin), .i_lp_xtal_in_sleep(lp_sl),
        .i_pll_lock(lock), .o_watchdog_enabled(en), .o_sw_watchdog_enable(swo),
        .o_watchdog_timeout_flag(tof), .o_watchdog_counter(cnt), .o_wdt_reset(wrst),
        .o_cpu_clk_en(cpu), .o_periph_clk_en(per), .o_osc_en(osc), .o_low_power_rc_clock_en(rc),
        .o_sleeping(slp), .o_idle(idl), .o_osc_source(src));
    wsw_core_model i_wsw_core_model (.i_clk(clk), .i_kick_en(kick), .i_req(req), .i_mode(mode),
        .o_clear(clr), .o_psav(psav), .o_mode(pmode));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rc_write(input logic [7:0] v);
        rcw = v;
        rcwe = 1'b1;
        cyc(1);
        rcwe = 1'b0;
        cyc(1);
    endtask
    // requests go by non-blocking write so the core model sees them one edge later
    task automatic psave(input logic m);
        mode <= m;
        req <= 1'b1;
        cyc(1);
        req <= 1'b0;
        cyc(3);
    endtask
    task automatic wake(input logic [1:0] o, input logic l, input int how, input int hold,
                        input int lim, input logic [1:0] want);
        int k;
        cur = o;
        lp_sl = l;
        lock = 1'b0;
        psave(PSAV_SLEEP);
        chk("sleeping", 1, slp);
        chk("clocks off", {2'h0, l}, {cpu, per, osc});
        chk("rc on", 1, rc);
        // how: 0 interrupt, 1 power-on, 2 pin reset, 3 none, left to the watchdog
        irq = (how == 0);
        por = (how == 1);
        pin = (how == 2);
        cyc(1);
        {irq, por, pin} = 3'h0;
        cyc(hold);
        chk("held off", 0, cpu);
        lock = 1'b1;
        for (k = 0; k < lim && cpu !== 1'b1; k++) cyc(1);
        chk("resumed", 1, cpu);
        chk("source", want, src);
        $display("test wake from source %0d done", o);
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, about three times the expected run
    initial begin
        #300000;
        n_fail++;
        close_out();
    end

    initial begin
        {rst_n, cfg_en, erased, sw_ce, kick, req, mode, irq, por, pin, lp_sl, lock, rcwe} = '0;
        fam = 2'h0;
        cur = 2'h0;
        fmode = 4'h0;
        rcw = 8'h0;
        n_fail = 0;
        n_checks = 0;
        cyc(5);
        rst_n = 1'b1;
        cyc(1);
        chk("reset state", 16'h20, {cpu, slp, src, tof, cnt != 16'h0});
        chk("sw off", 0, en);
        rc_write(8'h20);
        chk("sw on", 3, {swo, en});
        c0 = cnt;
        cyc(40);
        chk("rc ticks", 10, cnt - c0);
        rc_write(8'h00);
        c0 = cnt;
        cyc(40);
        chk("held count", 0, cnt - c0);
        cfg_en = 1'b1;
        cyc(1);
        chk("cfg forces on", 1, en);
        cfg_en = 1'b0;
        erased = 1'b1;
        cyc(1);
        chk("erased on", 1, en);
        kick <= 1'b1;
        cyc(300);
        chk("kicked low", 1, cnt < 16'h8);
        $display("test enable and count done");
        sw_ce = 1'b1;
        wake(OSC_EXT_CLK, 1'b0, 0, 990, 16, OSC_EXT_CLK);
        wake(OSC_XTAL, 1'b0, 2, 12, 10, OSC_XTAL);
        wake(OSC_XTAL_PLL, 1'b0, 0, 1100, 1010, OSC_XTAL_PLL);
        wake(OSC_LP_XTAL, 1'b1, 0, 990, 16, OSC_LP_XTAL);
        fmode = 4'h8;
        wake(OSC_EXT_CLK, 1'b0, 1, 0, 6000, OSC_LP_XTAL);
        fmode = 4'h0;
        fam = OSC_XTAL;
        wake(OSC_EXT_CLK, 1'b0, 1, 0, 40, OSC_XTAL);
        // no clears: the watchdog runs out in run (512 ticks), then again in sleep
        kick <= 1'b0;
        for (wait_n = 0; wait_n < 2100 && wrst !== 1'b1; wait_n++) cyc(1);
        chk("watchdog reset", 1, wrst);
        chk("timeout flag set", 1, tof);
        chk("count wrapped", 0, cnt);
        cyc(1);
        chk("reset pulse ends", 0, wrst);
        wake(OSC_EXT_CLK, 1'b0, 3, 2500, 700, OSC_EXT_CLK);
        chk("timeout flag cleared", 0, tof);
        kick <= 1'b1;
        $display("test watchdog overflow done");
        psave(PSAV_IDLE);
        chk("idle", 3, {idl, !slp});
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        chk("run after reset", 2, {cpu, idl});
        $display("test idle done");
        close_out();
    end
endmodule

// File: wsw_core_model.sv
// partner: processor core issuing clear and power-save instructions
`timescale 1ns/100ps
module wsw_core_model import wsw_pkg::*; (
    // clock and commands from the bench
    input  wire logic i_clk,
    input  wire logic i_kick_en,
    input  wire logic i_req,
    input  wire logic i_mode,
    // instruction strobes
    output logic      o_clear,
    output logic      o_psav,
    output logic      o_mode
);
    logic [3:0] gap_ff;

    initial begin
        gap_ff = 4'h0;
        o_clear = 1'b0;
        o_psav = 1'b0;
        o_mode = 1'b0;
    end
    // software loop clears every 16 clocks, far inside the time-out
    always @(negedge i_clk) begin
        gap_ff <= gap_ff + 4'h1;
        o_clear <= i_kick_en && (gap_ff == 4'hf);
        o_psav <= i_req;
        o_mode <= i_mode;
    end
endmodule

// File: wsw_counter.sv
// enabled up-counter with terminal pulse, used for watchdog and delays
`timescale 1ns/100ps
module wsw_counter import wsw_pkg::*; #(
    parameter int unsigned W = 16
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // control
    input  wire logic         i_clear,
    input  wire logic         i_en,
    input  wire logic [W-1:0] i_limit,
    // status
    output logic              o_hit,
    output logic [W-1:0]      o_count
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         hit;
    } wsw_cnt_state_t;

    wsw_cnt_state_t cur_ff;
    wsw_cnt_state_t nxt_cur;

    // clear wins over counting; hit is one pulse at the limit
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.hit = 1'b0;
        if (i_clear) begin
            nxt_cur.cnt = '0;
        end else if (i_en) begin
            if (cur_ff.cnt == i_limit) begin
                nxt_cur.cnt = '0;
                nxt_cur.hit = 1'b1;
            end else begin
                nxt_cur.cnt = cur_ff.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign o_hit = cur_ff.hit;
    assign o_count = cur_ff.cnt;
endmodule

// File: wsw_pkg.sv
// package: constants and types for the watchdog, sleep and wake block
package wsw_pkg;
    // watchdog counter width and time-out (terminal count)
    localparam int unsigned WDT_WIDTH = 16;
    localparam logic [WDT_WIDTH-1:0] WDT_TERMINAL = 16'hffff;
    // software enable position in the reset control register
    localparam int unsigned SW_WDT_EN_BIT = 5;
    // erased (default) value of the configuration enable bit
    localparam logic CFG_WDT_EN_ERASED = 1'b1;
    // power-on delay, about 10 us, at 100 MHz
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_DELAY_NS = 10000;
    localparam int unsigned POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
    // power-up timer length, cycles (no figure given)
    localparam int unsigned POWER_UP_TIMER_CYC_DEF = 4096;
    // oscillator start-up timer length, cycles
    localparam int unsigned OST_CYC_DEF = 1024;
    localparam int unsigned DLY_WIDTH = 24;
    // rc oscillator divider: one watchdog tick per this many clocks
    localparam int unsigned RC_DIV = 4;
    // oscillator source encodings
    localparam logic [1:0] OSC_EXT_CLK = 2'h0;  // external clock or internal rc
    localparam logic [1:0] OSC_XTAL = 2'h1;     // crystal
    localparam logic [1:0] OSC_XTAL_PLL = 2'h2; // crystal with pll
    localparam logic [1:0] OSC_LP_XTAL = 2'h3;  // low-power crystal
    // power-save operand values
    localparam logic PSAV_SLEEP = 1'b0;
    localparam logic PSAV_IDLE = 1'b1;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_WAKE_OST,
        ST_WAKE_LOCK,
        ST_WAKE_DLY
    } wsw_state_t;
endpackage

// File: wsw_top.sv
// watchdog with sleep/idle entry, wake-up and clock restart hold-off
// Function
// - watchdog ticks from a divided low-power rc clock, independent of system clock
// - configuration enable bit at 1 forces the watchdog on permanently
// - erased configuration enable bit reads as 1, watchdog on by default
// - watchdog increments to overflow; overflow in run or idle forces device reset
// - overflow during sleep wakes the device instead of resetting it
// - wake by watchdog overflow clears the watchdog time-out flag
// - with configuration bit 0, software enable bit 5 controls the watchdog
// - sleep stops cpu and peripheral clocks, and the oscillator unless i_lp_xtal_in_sleep is set; rc runs if watchdog on
// - sleep exits on enabled interrupt, any reset or watchdog overflow
// - wake restarts the pre-sleep clock, chosen by current oscillator field
// - on wake from sleep by power-on or brown-out, oscillator comes from configuration fields
// - crystal wake holds clock until power-up and start-up timers end, or pll lock plus power-on delay
// - external clock or rc wake applies only the power-on delay
// - low-power crystal running in sleep: power-on delay only, no timers
`timescale 1ns/100ps
module wsw_top import wsw_pkg::*; #(
    parameter int unsigned          POWER_UP_TIMER_CYC  = POWER_UP_TIMER_CYC_DEF,
    parameter int unsigned          OST_CYC   = OST_CYC_DEF,
    // time-out is a parameter so that a short run can still reach an overflow
    parameter logic [WDT_WIDTH-1:0] WDT_LIMIT = WDT_TERMINAL
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // configuration word
    input  wire logic                 i_cfg_watchdog_enable,
    input  wire logic                 i_cfg_erased,
    input  wire logic [1:0]           i_cfg_osc_family,
    input  wire logic [3:0]           i_cfg_primary_osc_mode,
    input  wire logic                 i_clk_switch_en,
    input  wire logic [1:0]           i_current_osc_select,
    // reset control register bits
    input  wire logic [7:0]           i_reset_control_reg_wr,
    input  wire logic                 i_reset_control_reg_we,
    // core instructions
    input  wire logic                 i_clear_watchdog_instr,
    input  wire logic                 i_power_save_instr,
    input  wire logic                 i_power_save_mode,
    // wake sources, crystal-in-sleep and pll lock
    input  wire logic                 i_irq_wake,
    input  wire logic                 i_por_bor,
    input  wire logic                 i_pin_reset,
    input  wire logic                 i_lp_xtal_in_sleep,
    input  wire logic                 i_pll_lock,
    // status
    output logic                      o_watchdog_enabled,
    output logic                      o_sw_watchdog_enable,
    output logic                      o_watchdog_timeout_flag,
    output logic [WDT_WIDTH-1:0]      o_watchdog_counter,
    output logic                      o_wdt_reset,
    // clocks and power state
    output logic                      o_cpu_clk_en,
    output logic                      o_periph_clk_en,
    output logic                      o_osc_en,
    output logic                      o_low_power_rc_clock_en,
    output logic                      o_sleeping,
    output logic                      o_idle,
    output logic [1:0]                o_osc_source
);
    typedef struct packed {
        wsw_state_t  st;
        logic        sw_en;
        logic        watchdog_timeout_flag;
        logic        wdt_rst;
        logic [1:0]  osc;
        logic [1:0]  rc_div;
        logic        rc_tick;
        logic        wake_wdt;
    } wsw_top_state_t;

    wsw_top_state_t cur_ff;
    wsw_top_state_t nxt_cur;

    logic                 cfg_en;
    logic                 wdt_on;
    logic                 wdt_ovf;
    logic                 dly_hit;
    logic                 dly_run;
    logic                 dly_clr;
    logic [DLY_WIDTH-1:0] dly_limit;
    logic [1:0]           wake_osc;
    logic                 wake_any;

    // erased part reads as enabled
    assign cfg_en = i_cfg_erased ? CFG_WDT_EN_ERASED : i_cfg_watchdog_enable;
    // software bit only matters when the configuration bit is 0
    assign wdt_on = cfg_en | cur_ff.sw_en;

    // watchdog counter on the rc tick; stays counting regardless of cpu clock gating
    wsw_counter #(
        .W (WDT_WIDTH)
    ) u_wdt (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clear (i_clear_watchdog_instr | ~wdt_on | cur_ff.wdt_rst),
        .i_en    (cur_ff.rc_tick),
        .i_limit (WDT_LIMIT),
        .o_hit   (wdt_ovf),
        .o_count (o_watchdog_counter)
    );

    // wake hold-off timer, one counter shared by all delay kinds
    wsw_counter #(
        .W (DLY_WIDTH)
    ) u_dly (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_clear (dly_clr),
        .i_en    (dly_run),
        .i_limit (dly_limit),
        .o_hit   (dly_hit),
        .o_count ()
    );

    // oscillator choice: configuration fields after power-on, else pre-sleep clock
    always_comb begin
        if (i_por_bor) begin
            wake_osc = i_cfg_primary_osc_mode[3] ? OSC_LP_XTAL : i_cfg_osc_family;
        end else if (i_clk_switch_en) begin
            wake_osc = i_current_osc_select;
        end else begin
            wake_osc = cur_ff.osc;
        end
    end

    assign wake_any = i_irq_wake | i_por_bor | i_pin_reset | wdt_ovf;

    // hold-off length follows the state being waited in
    always_comb begin
        dly_run = 1'b0;
        dly_limit = DLY_WIDTH'(POR_DELAY_CYC - 1);
        case (cur_ff.st)
            ST_WAKE_OST: begin
                dly_run = 1'b1;
                dly_limit = DLY_WIDTH'(OST_CYC + POWER_UP_TIMER_CYC - 1);
            end
            ST_WAKE_DLY: begin
                dly_run = 1'b1;
                dly_limit = DLY_WIDTH'(POR_DELAY_CYC - 1);
            end
            default: begin
                dly_run = 1'b0;
            end
        endcase
    end

    // delay counter restarts on every state change
    assign dly_clr = (nxt_cur.st != cur_ff.st);

    // main power-state machine
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.wdt_rst = 1'b0;
        nxt_cur.rc_tick = 1'b0;
        // rc divider runs whenever the watchdog is on, asleep or not
        if (wdt_on) begin
            nxt_cur.rc_div = cur_ff.rc_div + 2'h1;
            nxt_cur.rc_tick = (cur_ff.rc_div == 2'(RC_DIV - 1));
        end
        if (i_reset_control_reg_we) begin
            nxt_cur.sw_en = i_reset_control_reg_wr[SW_WDT_EN_BIT];
            nxt_cur.watchdog_timeout_flag = i_reset_control_reg_wr[4];
        end
        case (cur_ff.st)
            ST_RUN: begin
                if (wdt_ovf) begin
                    nxt_cur.wdt_rst = 1'b1;
                    nxt_cur.watchdog_timeout_flag = 1'b1;
                end else if (i_power_save_instr) begin
                    nxt_cur.osc = i_current_osc_select;
                    nxt_cur.st = (i_power_save_mode == PSAV_SLEEP) ? ST_SLEEP : ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wdt_ovf) begin
                    nxt_cur.wdt_rst = 1'b1;
                    nxt_cur.watchdog_timeout_flag = 1'b1;
                    nxt_cur.st = ST_RUN;
                end else if (i_irq_wake | i_por_bor | i_pin_reset) begin
                    nxt_cur.st = ST_RUN;
                end
            end
            ST_SLEEP: begin
                if (wake_any) begin
                    nxt_cur.wake_wdt = wdt_ovf & ~i_por_bor & ~i_pin_reset;
                    if (wdt_ovf) begin
                        nxt_cur.watchdog_timeout_flag = 1'b0;
                    end
                    nxt_cur.osc = wake_osc;
                    if (wake_osc == OSC_LP_XTAL && i_lp_xtal_in_sleep) begin
                        nxt_cur.st = ST_WAKE_DLY;
                    end else if (wake_osc == OSC_XTAL || wake_osc == OSC_LP_XTAL) begin
                        nxt_cur.st = ST_WAKE_OST;
                    end else if (wake_osc == OSC_XTAL_PLL) begin
                        nxt_cur.st = ST_WAKE_LOCK;
                    end else begin
                        nxt_cur.st = ST_WAKE_DLY;
                    end
                end
            end
            ST_WAKE_OST: begin
                if (dly_hit) begin
                    nxt_cur.st = ST_RUN;
                end
            end
            ST_WAKE_LOCK: begin
                // clock held until the pll reports lock
                if (i_pll_lock) begin
                    nxt_cur.st = ST_WAKE_DLY;
                end
            end
            ST_WAKE_DLY: begin
                if (dly_hit) begin
                    nxt_cur.st = ST_RUN;
                end
            end
            default: begin
                nxt_cur.st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cur_ff <= '{st: ST_RUN, sw_en: 1'b0, watchdog_timeout_flag: 1'b0, wdt_rst: 1'b0, osc: 2'h0,
                        rc_div: 2'h0, rc_tick: 1'b0, wake_wdt: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs; sleep gates cpu and peripheral clocks, and the oscillator unless i_lp_xtal_in_sleep is set
    assign o_watchdog_enabled = wdt_on;
    assign o_sw_watchdog_enable = cur_ff.sw_en;
    assign o_watchdog_timeout_flag = cur_ff.watchdog_timeout_flag;
    assign o_wdt_reset = cur_ff.wdt_rst;
    assign o_cpu_clk_en = (cur_ff.st == ST_RUN);
    assign o_periph_clk_en = (cur_ff.st == ST_RUN) || (cur_ff.st == ST_IDLE);
    assign o_osc_en = (cur_ff.st != ST_SLEEP) || i_lp_xtal_in_sleep;
    assign o_low_power_rc_clock_en = wdt_on;
    assign o_sleeping = (cur_ff.st == ST_SLEEP);
    assign o_idle = (cur_ff.st == ST_IDLE);
    assign o_osc_source = cur_ff.osc;
endmodule

// File: wsw_top_properties.sv
// checker: watchdog count, enable, sleep entry and wake hold-off properties
`timescale 1ns/100ps
module wsw_top_properties import wsw_pkg::*; (
    // clock, reset and watched inputs
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_cfg_watchdog_enable,
    input wire logic                 i_cfg_erased,
    input wire logic                 i_clear_watchdog_instr,
    input wire logic                 i_power_save_instr,
    input wire logic                 i_power_save_mode,
    input wire logic                 i_lp_xtal_in_sleep,
    // watched outputs
    input wire logic                 o_watchdog_enabled,
    input wire logic [WDT_WIDTH-1:0] o_watchdog_counter,
    input wire logic                 o_wdt_reset,
    input wire logic                 o_cpu_clk_en,
    input wire logic                 o_periph_clk_en,
    input wire logic                 o_osc_en,
    input wire logic                 o_low_power_rc_clock_en,
    input wire logic                 o_sleeping,
    input wire logic                 o_idle
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    clear_zero_a : assert property (i_clear_watchdog_instr |=> o_watchdog_counter == 16'h0)
        else $error("counter not zero after clear");
    cfg_force_a : assert property (i_cfg_watchdog_enable |-> o_watchdog_enabled)
        else $error("watchdog off with config bit set");
    erased_on_a : assert property (i_cfg_erased |-> o_watchdog_enabled)
        else $error("watchdog off on erased part");
    count_step_a : assert property (!$stable(o_watchdog_counter) |->
        (o_watchdog_counter == $past(o_watchdog_counter) + 16'h1) || (o_watchdog_counter == 16'h0))
        else $error("counter jumped");
    // a tick takes four clocks; a clear may land between ticks, so only a step up starts the check
    tick_rate_a : assert property ($changed(o_watchdog_counter) && o_watchdog_counter != 16'h0 |=>
        (o_watchdog_counter == $past(o_watchdog_counter) || o_watchdog_counter == 16'h0) [*3])
        else $error("counter ticks faster than rc rate");
    // an overflow registered just before the switch-off still gives one pulse
    sw_off_a : assert property (!o_watchdog_enabled [*2] |=> !o_wdt_reset)
        else $error("reset from disabled watchdog");
    // oscillator may only run on when the low-power crystal is kept alive
    sleep_clk_a : assert property (o_sleeping |->
        !o_cpu_clk_en && !o_periph_clk_en && (o_osc_en == i_lp_xtal_in_sleep))
        else $error("clock running in sleep");
    rc_keep_a : assert property (o_sleeping && o_watchdog_enabled |-> o_low_power_rc_clock_en)
        else $error("rc clock stopped in sleep");
    // overflow in run wins over the request and gives the reset pulse instead
    sleep_entry_a : assert property (o_cpu_clk_en && !o_idle && i_power_save_instr
        && i_power_save_mode == PSAV_SLEEP |=> o_sleeping ^ o_wdt_reset)
        else $error("sleep not entered");
    // the cycle after sleep is watched too, where a reset from a sleep overflow would show
    no_reset_sleep_a : assert property (o_sleeping |-> !o_wdt_reset ##1 !o_wdt_reset)
        else $error("device reset during sleep");
    pulse_one_a : assert property (o_wdt_reset |=> !o_wdt_reset)
        else $error("reset pulse too long");
    wake_hold_a : assert property ($fell(o_sleeping) |-> !o_cpu_clk_en [*8])
        else $error("clock resumed without delay");
endmodule

bind wsw_top wsw_top_properties i_props (.i_clk, .i_rst_n, .i_cfg_watchdog_enable, .i_cfg_erased,
    .i_clear_watchdog_instr, .i_power_save_instr, .i_power_save_mode, .i_lp_xtal_in_sleep, .o_watchdog_enabled,
    .o_watchdog_counter, .o_wdt_reset, .o_cpu_clk_en, .o_periph_clk_en, .o_osc_en,
    .o_low_power_rc_clock_en, .o_sleeping, .o_idle);
